// ===== hw/ovuv_pkg.sv
package ovuv_pkg;

    localparam int CHANNELS = 16;
    localparam int LEVEL_W = 8;
    localparam int CLK_MHZ = 250;

    // Register byte offsets on the word-wide bus
    localparam logic [7:0] OFF_OVER_LEVEL = 8'h00;
    localparam logic [7:0] OFF_UNDER_LEVEL = 8'h04;
    localparam logic [7:0] OFF_UNDER_MASK_LO = 8'h08;
    localparam logic [7:0] OFF_UNDER_MASK_HI = 8'h0C;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_STATE_FLAGS = 8'h14;
    localparam logic [7:0] OFF_OVER_FAULT_LO = 8'h18;
    localparam logic [7:0] OFF_OVER_FAULT_HI = 8'h1C;
    localparam logic [7:0] OFF_UNDER_FAULT_LO = 8'h20;
    localparam logic [7:0] OFF_UNDER_FAULT_HI = 8'h24;

    // Field positions
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_LAUNCH_BIT = 2;
    localparam int CTRL_PICK_LSB = 4;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_BIST_PASS_BIT = 1;
    localparam int STAT_SETTLING_BIT = 2;

    // Reset values
    localparam logic [LEVEL_W-1:0] RST_OVER_LEVEL = 8'hFF;
    localparam logic [LEVEL_W-1:0] RST_UNDER_LEVEL = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [1:0] RST_RUN_SELECT = 2'h0;
    localparam logic [3:0] RST_CHANNEL_PICK = 4'h0;

    // Run-select encodings
    localparam logic [1:0] RUN_STOP = 2'h0;
    localparam logic [1:0] RUN_ROBIN = 2'h1;
    localparam logic [1:0] RUN_BIST = 2'h2;
    localparam logic [1:0] RUN_LOCK = 2'h3;

    // Timing
    localparam int SLOT_TIME_NS = 1000;
    localparam int SLOT_CYCLES = SLOT_TIME_NS * CLK_MHZ / 1000;
    localparam int FRONT_END_SETTLE_TIME_NS = 2000;
    localparam int SETTLE_CYCLES = (FRONT_END_SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int BIST_PHASE_SLOTS = 2;

    localparam logic [15:0] ADC_FORCE_VALUE = 16'h8000;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [3:0] {
        ST_STOP = 4'b0001,
        ST_ROBIN = 4'b0010,
        ST_BIST = 4'b0100,
        ST_LOCK = 4'b1000
    } protState_t;

    typedef struct packed {
        logic [1:0] runSel;
        logic [LEVEL_W-1:0] overLevel;
        logic [LEVEL_W-1:0] underLevel;
        logic [CHANNELS-1:0] underMask;
    } launchCopy_t;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
    } busReq_t;

endpackage : ovuv_pkg

// ===== hw/overvoltage_undervoltage_protector_ctrl.sv
// Decided for this implementation: register access over AHB-Lite and the address map.
module overvoltage_undervoltage_protector_ctrl #(
    parameter int SLOT_CYCLES = ovuv_pkg::SLOT_CYCLES,
    parameter int SETTLE_CYCLES = ovuv_pkg::SETTLE_CYCLES
) (
    input wire logic clk, // 250 MHz clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic [1:0] hresp, // Always OKAY
    input wire logic overCmpPin, // Over comparator output, analog side
    input wire logic underCmpPin, // Under comparator output, analog side
    input wire logic adcRunning, // Main ADC converting
    input wire logic shutdownReq, // Device shutting down
    output logic [3:0] muxChannel, // Sensed channel routed to comparators
    output logic [ovuv_pkg::LEVEL_W-1:0] overDac, // Over threshold DAC code
    output logic [ovuv_pkg::LEVEL_W-1:0] underDac, // Under threshold DAC code
    output logic bistStimOver, // Self-test stimulus above over level
    output logic bistStimUnder, // Self-test stimulus below under level
    output logic adcResultHold, // Freeze ADC result registers
    output logic adcResultForce, // Force ADC results to fixed code
    output logic protectorActive // Protectors running
);

    localparam int CH = ovuv_pkg::CHANNELS;
    localparam int LW = ovuv_pkg::LEVEL_W;
    localparam int SLOT_W = $clog2(SLOT_CYCLES + 1);
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYCLES - 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES);

    if (SLOT_CYCLES < 4 || SETTLE_CYCLES < 1 || CH != 16)
    begin : gen_bad_param
        $error("Slot needs four cycles, settle one, and sixteen channels");
    end

    ovuv_pkg::protState_t state;
    ovuv_pkg::launchCopy_t live;
    ovuv_pkg::launchCopy_t copy;
    ovuv_pkg::busReq_t req;
    logic reqPending;
    logic [3:0] channelPick;
    logic overSync1;
    logic overSync2;
    logic underSync1;
    logic underSync2;
    logic [SLOT_W-1:0] slotCnt;
    logic [3:0] robinCh;
    logic bistPhase;
    logic [1:0] bistSlot;
    logic bistOverOk;
    logic bistPass;
    logic [SETTLE_W-1:0] settleCnt;
    logic heldAtStart;
    logic [CH-1:0] overFault;
    logic [CH-1:0] underFault;
    logic [CH-1:0] overClr;
    logic [CH-1:0] underClr;
    logic [CH-1:0] overSet;
    logic [CH-1:0] underSet;
    logic launchPulse;
    logic wrStrobe;
    logic slotEnd;
    logic sampleNow;
    logic bistEnd;
    logic adcBlocked;
    logic [3:0] next_channel;
    logic [31:0] next_rdata;

    assign wrStrobe = reqPending && req.write;
    assign launchPulse = wrStrobe && req.addr == ovuv_pkg::OFF_CONTROL
        && hwdata[ovuv_pkg::CTRL_LAUNCH_BIT];
    assign slotEnd = slotCnt == '0;
    assign bistEnd = state == ovuv_pkg::ST_BIST && slotEnd && bistPhase
        && bistSlot == 2'(ovuv_pkg::BIST_PHASE_SLOTS - 1);
    // Self test samples nothing into the fault flags
    assign sampleNow = slotEnd && (state == ovuv_pkg::ST_ROBIN
        || state == ovuv_pkg::ST_LOCK);
    assign adcBlocked = state == ovuv_pkg::ST_BIST || settleCnt != '0;

    // Bus slave: one wait state on every transfer, so a read always sees
    // a write that ended just before it
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            reqPending <= 1'b0;
            req <= '0;
            hreadyout <= 1'b1;
        end
        else if (reqPending)
        begin
            reqPending <= 1'b0;
            hreadyout <= 1'b1;
        end
        else if (hsel && hready && htrans[1])
        begin
            reqPending <= 1'b1;
            req.write <= hwrite;
            req.addr <= {haddr[7:2], 2'b00};
            hreadyout <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            hresp <= ovuv_pkg::HRESP_OKAY;
        else
            hresp <= ovuv_pkg::HRESP_OKAY;
    end

    // Live settings; the running logic sees the launch copy, except channelPick, which lock mode reads live
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            live.overLevel <= ovuv_pkg::RST_OVER_LEVEL;
            live.underLevel <= ovuv_pkg::RST_UNDER_LEVEL;
            live.underMask <= {ovuv_pkg::RST_MASK, ovuv_pkg::RST_MASK};
            live.runSel <= ovuv_pkg::RST_RUN_SELECT;
            channelPick <= ovuv_pkg::RST_CHANNEL_PICK;
        end
        else if (wrStrobe)
        begin
            case (req.addr)
                ovuv_pkg::OFF_OVER_LEVEL: live.overLevel <= hwdata[LW-1:0];
                ovuv_pkg::OFF_UNDER_LEVEL: live.underLevel <= hwdata[LW-1:0];
                ovuv_pkg::OFF_UNDER_MASK_LO: live.underMask[7:0] <= hwdata[7:0];
                ovuv_pkg::OFF_UNDER_MASK_HI: live.underMask[15:8] <= hwdata[7:0];
                ovuv_pkg::OFF_CONTROL:
                begin
                    live.runSel <= hwdata[ovuv_pkg::CTRL_RUN_LSB +: 2];
                    channelPick <= hwdata[ovuv_pkg::CTRL_PICK_LSB +: 4];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        next_rdata = '0;
        case (req.addr)
            ovuv_pkg::OFF_OVER_LEVEL: next_rdata[LW-1:0] = live.overLevel;
            ovuv_pkg::OFF_UNDER_LEVEL: next_rdata[LW-1:0] = live.underLevel;
            ovuv_pkg::OFF_UNDER_MASK_LO: next_rdata[7:0] = live.underMask[7:0];
            ovuv_pkg::OFF_UNDER_MASK_HI: next_rdata[7:0] = live.underMask[15:8];
            ovuv_pkg::OFF_CONTROL:
            begin
                next_rdata[ovuv_pkg::CTRL_RUN_LSB +: 2] = live.runSel;
                next_rdata[ovuv_pkg::CTRL_PICK_LSB +: 4] = channelPick;
            end
            ovuv_pkg::OFF_STATE_FLAGS:
            begin
                next_rdata[ovuv_pkg::STAT_ACTIVE_BIT] = protectorActive;
                next_rdata[ovuv_pkg::STAT_BIST_PASS_BIT] = bistPass;
                next_rdata[ovuv_pkg::STAT_SETTLING_BIT] = settleCnt != '0;
            end
            ovuv_pkg::OFF_OVER_FAULT_LO: next_rdata[7:0] = overFault[7:0];
            ovuv_pkg::OFF_OVER_FAULT_HI: next_rdata[7:0] = overFault[15:8];
            ovuv_pkg::OFF_UNDER_FAULT_LO: next_rdata[7:0] = underFault[7:0];
            ovuv_pkg::OFF_UNDER_FAULT_HI: next_rdata[7:0] = underFault[15:8];
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            hrdata <= '0;
        else if (reqPending && !req.write)
            hrdata <= next_rdata;
    end

    // Levels and under mask are taken only at launch; later writes wait for
    // the next one, but a channelPick write reaches lock mode at once
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            copy.overLevel <= ovuv_pkg::RST_OVER_LEVEL;
            copy.underLevel <= ovuv_pkg::RST_UNDER_LEVEL;
            copy.underMask <= {ovuv_pkg::RST_MASK, ovuv_pkg::RST_MASK};
            copy.runSel <= ovuv_pkg::RST_RUN_SELECT;
        end
        else if (launchPulse)
        begin
            copy.overLevel <= live.overLevel;
            copy.underLevel <= live.underLevel;
            copy.underMask <= live.underMask;
            copy.runSel <= hwdata[ovuv_pkg::CTRL_RUN_LSB +: 2];
        end
    end

    // No sleep input: once launched the run goes on until a stop launch,
    // the end of a self test, or shutdown
    always_ff @(posedge clk)
    begin
        if (!rst_b || shutdownReq)
            state <= ovuv_pkg::ST_STOP;
        else if (launchPulse)
        begin
            case (hwdata[ovuv_pkg::CTRL_RUN_LSB +: 2])
                ovuv_pkg::RUN_ROBIN: state <= ovuv_pkg::ST_ROBIN;
                ovuv_pkg::RUN_BIST: state <= ovuv_pkg::ST_BIST;
                ovuv_pkg::RUN_LOCK: state <= ovuv_pkg::ST_LOCK;
                default: state <= ovuv_pkg::ST_STOP;
            endcase
        end
        else if (bistEnd)
            state <= ovuv_pkg::ST_STOP;
    end

    // Every slot lasts the same whether masked or not, so the round robin
    // period never depends on how many channels are in use
    always_ff @(posedge clk)
    begin
        if (!rst_b || launchPulse || state == ovuv_pkg::ST_STOP)
            slotCnt <= SLOT_LAST;
        else if (slotEnd)
            slotCnt <= SLOT_LAST;
        else
            slotCnt <= slotCnt - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || launchPulse)
            robinCh <= '0;
        else if (state == ovuv_pkg::ST_ROBIN && slotEnd)
            robinCh <= robinCh + 1'b1;
    end

    always_comb
    begin
        case (state)
            ovuv_pkg::ST_LOCK: next_channel = channelPick;
            ovuv_pkg::ST_ROBIN: next_channel = robinCh;
            default: next_channel = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            muxChannel <= '0;
            overDac <= ovuv_pkg::RST_OVER_LEVEL;
            underDac <= ovuv_pkg::RST_UNDER_LEVEL;
            protectorActive <= 1'b0;
        end
        else
        begin
            muxChannel <= shutdownReq ? 4'h0 : next_channel;
            overDac <= copy.overLevel;
            underDac <= copy.underLevel;
            protectorActive <= state != ovuv_pkg::ST_STOP && !bistEnd
                && !shutdownReq;
        end
    end

    // Comparator outputs come from the analog side
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            overSync1 <= 1'b0;
            overSync2 <= 1'b0;
            underSync1 <= 1'b0;
            underSync2 <= 1'b0;
        end
        else
        begin
            overSync1 <= overCmpPin;
            overSync2 <= overSync1;
            underSync1 <= underCmpPin;
            underSync2 <= underSync1;
        end
    end

    // Self test: drive the over stimulus for some slots, then the under
    // one, and expect each comparator to trip
    always_ff @(posedge clk)
    begin
        if (!rst_b || launchPulse)
        begin
            bistPhase <= 1'b0;
            bistSlot <= '0;
            bistOverOk <= 1'b0;
        end
        else if (state == ovuv_pkg::ST_BIST && slotEnd)
        begin
            if (bistSlot == 2'(ovuv_pkg::BIST_PHASE_SLOTS - 1))
            begin
                bistSlot <= '0;
                bistPhase <= 1'b1;
                if (!bistPhase)
                    bistOverOk <= overSync2;
            end
            else
                bistSlot <= bistSlot + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bistStimOver <= 1'b0;
            bistStimUnder <= 1'b0;
            bistPass <= 1'b0;
        end
        else
        begin
            bistStimOver <= state == ovuv_pkg::ST_BIST && !bistPhase && !launchPulse;
            bistStimUnder <= state == ovuv_pkg::ST_BIST && bistPhase && !bistEnd
                && !launchPulse;
            if (launchPulse)
                bistPass <= 1'b0;
            else if (bistEnd)
                bistPass <= bistOverOk && underSync2;
        end
    end

    // ADC interlock; a self test cut short by a new launch still settles
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            settleCnt <= '0;
        else if (state == ovuv_pkg::ST_BIST && (bistEnd || launchPulse || shutdownReq))
            settleCnt <= SETTLE_LOAD;
        else if (settleCnt != '0)
            settleCnt <= settleCnt - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            heldAtStart <= 1'b0;
        else if (!adcBlocked)
            heldAtStart <= adcRunning;
    end

    // Host is expected to have stopped the ADC first; both cases are still
    // handled so results never show test levels
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            adcResultHold <= 1'b0;
            adcResultForce <= 1'b0;
        end
        else
        begin
            adcResultHold <= adcBlocked && heldAtStart;
            adcResultForce <= adcBlocked && !heldAtStart && adcRunning;
        end
    end

    // Flags are sampled from the comparators only, never from ADC data
    generate
        for (genvar i = 0; i < CH; i++)
        begin : gen_flag
            assign overSet[i] = sampleNow && muxChannel == 4'(i) && overSync2;
            assign underSet[i] = sampleNow && muxChannel == 4'(i) && underSync2
                && !copy.underMask[i];
            assign overClr[i] = wrStrobe && hwdata[i % 8] && (i < 8
                ? req.addr == ovuv_pkg::OFF_OVER_FAULT_LO
                : req.addr == ovuv_pkg::OFF_OVER_FAULT_HI);
            assign underClr[i] = wrStrobe && hwdata[i % 8] && (i < 8
                ? req.addr == ovuv_pkg::OFF_UNDER_FAULT_LO
                : req.addr == ovuv_pkg::OFF_UNDER_FAULT_HI);

            // A detection in the clearing cycle wins
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    overFault[i] <= 1'b0;
                    underFault[i] <= 1'b0;
                end
                else
                begin
                    overFault[i] <= (overFault[i] && !overClr[i]) || overSet[i];
                    underFault[i] <= (underFault[i] && !underClr[i]) || underSet[i];
                end
            end
        end
    endgenerate

endmodule : overvoltage_undervoltage_protector_ctrl

// ===== verification/protector_control_sva.sv
module protector_ctrl_sva #(
    parameter int SLOT_CYCLES = 8,
    parameter int SETTLE_CYCLES = 10
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic [1:0] hresp, // Response
    input wire logic overCmpPin, // Over comparator
    input wire logic underCmpPin, // Under comparator
    input wire logic adcRunning, // ADC converting
    input wire logic shutdownReq, // Shutdown
    input wire logic [3:0] muxChannel, // Routed channel
    input wire logic [ovuv_pkg::LEVEL_W-1:0] overDac, // Over DAC
    input wire logic [ovuv_pkg::LEVEL_W-1:0] underDac, // Under DAC
    input wire logic bistStimOver, // Over stimulus
    input wire logic bistStimUnder, // Under stimulus
    input wire logic adcResultHold, // Result freeze
    input wire logic adcResultForce, // Result force
    input wire logic protectorActive // Running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence busTaken;
        hsel && hready && htrans[1] && hreadyout;
    endsequence
    sequence oneWait;
        !hreadyout ##1 hreadyout;
    endsequence
    // Wrap to channel 0 is left out: it looks the same as a stop
    sequence robinStep;
        $changed(muxChannel) && $past(muxChannel) != 4'h0 && muxChannel != 4'h0 && protectorActive;
    endsequence

    one_wait_a: assert property (busTaken |=> oneWait)
        else $error("transfer did not end after one wait state");
    resp_okay_a: assert property (hresp == ovuv_pkg::HRESP_OKAY)
        else $error("response not OKAY");
    // DAC codes move two edges after the launching write's wait state
    dac_capture_a: assert property (($changed(overDac) || $changed(underDac))
        |-> !$past(hreadyout, 2))
        else $error("threshold DAC changed outside a register write");
    robin_order_a: assert property (robinStep |-> muxChannel == $past(muxChannel) + 4'h1)
        else $error("round robin skipped a channel");
    slot_hold_a: assert property (robinStep |=> $stable(muxChannel) [*3])
        else $error("round robin slot cut short");
    mux_active_a: assert property (muxChannel != 4'h0 |=> protectorActive || muxChannel == 4'h0)
        else $error("channel routed while protectors idle");
    hold_force_a: assert property (!(adcResultHold && adcResultForce))
        else $error("ADC results held and forced together");
    force_cause_a: assert property (adcResultForce |-> $past(adcRunning))
        else $error("ADC results forced while ADC idle");
    stim_excl_a: assert property (bistStimOver |-> !bistStimUnder && muxChannel == 4'h0)
        else $error("self-test stimulus overlap or channel routed");
    shutdown_stop_a: assert property (shutdownReq [*3] |=> !protectorActive)
        else $error("protectors still running in shutdown");
endmodule : protector_ctrl_sva

bind overvoltage_undervoltage_protector_ctrl protector_ctrl_sva #(
    .SLOT_CYCLES(SLOT_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) sva (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .overCmpPin(overCmpPin),
    .underCmpPin(underCmpPin), .adcRunning(adcRunning), .shutdownReq(shutdownReq),
    .muxChannel(muxChannel), .overDac(overDac), .underDac(underDac),
    .bistStimOver(bistStimOver), .bistStimUnder(bistStimUnder),
    .adcResultHold(adcResultHold), .adcResultForce(adcResultForce),
    .protectorActive(protectorActive)
);

// ===== verification/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLOT = 8;
    localparam int SETTLE = 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [1:0] hresp;
    logic overCmpPin = 1'b0;
    logic underCmpPin = 1'b0;
    logic adcRunning = 1'b0;
    logic shutdownReq = 1'b0;
    logic stimOn = 1'b0;
    logic [3:0] muxChannel;
    logic [ovuv_pkg::LEVEL_W-1:0] overDac;
    logic [ovuv_pkg::LEVEL_W-1:0] underDac;
    logic bistStimOver;
    logic bistStimUnder;
    logic adcResultHold;
    logic adcResultForce;
    logic protectorActive;
    logic [31:0] rd;
    int miscompares = 0;
    int comparisons = 0;
    int n;

    always #2 clk = ~clk;

    overvoltage_undervoltage_protector_ctrl #(.SLOT_CYCLES(SLOT), .SETTLE_CYCLES(SETTLE)) dut (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .overCmpPin(overCmpPin),
        .underCmpPin(underCmpPin), .adcRunning(adcRunning), .shutdownReq(shutdownReq),
        .muxChannel(muxChannel), .overDac(overDac), .underDac(underDac),
        .bistStimOver(bistStimOver), .bistStimUnder(bistStimUnder),
        .adcResultHold(adcResultHold), .adcResultForce(adcResultForce),
        .protectorActive(protectorActive)
    );

    // Comparators trip on ch3/ch12 (over) and ch2/ch9 (under), or on self-test stimulus
    always @(posedge clk)
    begin
        overCmpPin <= bistStimOver || (stimOn && (muxChannel == 4'h3 || muxChannel == 4'hC));
        underCmpPin <= bistStimUnder || (stimOn && (muxChannel == 4'h2 || muxChannel == 4'h9));
    end

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic timeout();
        miscompares++;
        $display("MISMATCH at %0t: wait ran out, got %h expected %h", $time, 32'h0, 32'h1);
        finish_test();
    endtask : timeout

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] data);
        int k;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        // Address edge already passed, so the slave is busy at the next edge
        do
        begin
            @(posedge clk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        data = hrdata;
        if (k >= 50)
            timeout();
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask : rd_chk

    task automatic cycles(input int c);
        repeat (c) @(posedge clk);
    endtask : cycles

    task automatic wait_idle();
        int k;
        k = 0;
        while (protectorActive !== 1'b0 && k < 500)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 500)
            timeout();
    endtask : wait_idle

    initial
    begin
        repeat (20000) @(posedge clk);
        timeout();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd_chk(ovuv_pkg::OFF_OVER_LEVEL, 32'hFF);
        rd_chk(ovuv_pkg::OFF_UNDER_LEVEL, 32'h0);
        rd_chk(ovuv_pkg::OFF_STATE_FLAGS, 32'h0);
        wr(8'h40, 32'h5A);
        rd_chk(8'h40, 32'h0);
        wr(ovuv_pkg::OFF_OVER_LEVEL, 32'hA5);
        wr(ovuv_pkg::OFF_UNDER_LEVEL, 32'h3C);
        wr(ovuv_pkg::OFF_UNDER_MASK_HI, 32'h02);
        rd_chk(ovuv_pkg::OFF_OVER_LEVEL, 32'hA5);
        check({24'h0, overDac}, 32'hFF);
        stimOn <= 1'b1;
        // Launch happens while awake; the run then carries on with no further writes
        wr(ovuv_pkg::OFF_CONTROL, 32'h05);
        cycles(2);
        check({24'h0, overDac}, 32'hA5);
        check({24'h0, underDac}, 32'h3C);
        check({31'h0, protectorActive}, 32'h1);
        // One sweep: ch9 is masked but must keep its full slot
        n = 0;
        while (muxChannel !== 4'h1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        for (int ch = 1; ch < 16; ch++)
        begin
            check({28'h0, muxChannel}, 32'(ch));
            n = 0;
            while (muxChannel === 4'(ch) && n < 40)
            begin
                @(posedge clk);
                n++;
            end
            check(32'(n), 32'(SLOT));
        end
        stimOn <= 1'b0;
        cycles(150);
        rd_chk(ovuv_pkg::OFF_OVER_FAULT_LO, 32'h08);
        rd_chk(ovuv_pkg::OFF_OVER_FAULT_HI, 32'h10);
        rd_chk(ovuv_pkg::OFF_UNDER_FAULT_LO, 32'h04);
        rd_chk(ovuv_pkg::OFF_UNDER_FAULT_HI, 32'h00);
        wr(ovuv_pkg::OFF_OVER_FAULT_LO, 32'h08);
        rd_chk(ovuv_pkg::OFF_OVER_FAULT_LO, 32'h00);
        wr(ovuv_pkg::OFF_OVER_FAULT_HI, 32'hFF);
        wr(ovuv_pkg::OFF_UNDER_FAULT_LO, 32'hFF);
        check({31'h0, protectorActive}, 32'h1);
        shutdownReq <= 1'b1;
        cycles(4);
        check({31'h0, protectorActive}, 32'h0);
        shutdownReq <= 1'b0;
        wr(ovuv_pkg::OFF_CONTROL, 32'h57);
        cycles(2);
        n = 0;
        while (muxChannel === 4'h5 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        check(32'(n), 32'd40);
        wr(ovuv_pkg::OFF_CONTROL, 32'h04);
        cycles(2);
        check({27'h0, muxChannel, protectorActive}, 32'h0);
        adcRunning <= 1'b1;
        wr(ovuv_pkg::OFF_CONTROL, 32'h06);
        cycles(3);
        check({30'h0, adcResultHold, adcResultForce}, 32'h2);
        wait_idle();
        check({30'h0, adcResultHold, adcResultForce}, 32'h2);
        cycles(SETTLE + 2);
        check({30'h0, adcResultHold, adcResultForce}, 32'h0);
        rd_chk(ovuv_pkg::OFF_STATE_FLAGS, 32'h2);
        rd_chk(ovuv_pkg::OFF_OVER_FAULT_LO, 32'h0);
        rd_chk(ovuv_pkg::OFF_UNDER_FAULT_LO, 32'h0);
        adcRunning <= 1'b0;
        wr(ovuv_pkg::OFF_CONTROL, 32'h06);
        cycles(4);
        adcRunning <= 1'b1;
        cycles(2);
        check({30'h0, adcResultHold, adcResultForce}, 32'h1);
        wait_idle();
        cycles(SETTLE + 2);
        check({30'h0, adcResultHold, adcResultForce}, 32'h0);
        adcRunning <= 1'b0;
        finish_test();
    end
endmodule : tb_top
